// [logic/hfs_defs.svh]
`ifndef HFS_DEFS_SVH
`define HFS_DEFS_SVH

// Register indices; byte address is four times the index
`define HFS_IDX_STATUS 8'h05
`define HFS_IDX_CRC_COUNT 8'h21
`define HFS_IDX_FAR_END_BLOCK_ERROR_COUNT 8'h22
`define HFS_IDX_IRQ_STATUS 8'h30
`define HFS_IDX_IRQ_MASK 8'h31
`define HFS_IDX_FILL_TARGET 8'hcd

// Status register fields
`define HFS_ST_COUNT_LSB 0
`define HFS_ST_STATE_LSB 3
`define HFS_ST_MISMATCH 5
`define HFS_ST_CRC_SAT 6
`define HFS_ST_FAR_END_BLOCK_ERROR_SAT 7

// Interrupt status and mask fields
`define HFS_IRQ_STATE 0
`define HFS_IRQ_CRC_SAT 1
`define HFS_IRQ_FAR_END_BLOCK_ERROR_SAT 2
`define HFS_IRQ_BITS 3

// Reset values and frame count maximum
`define HFS_FILL_TARGET_RST 8'h00
`define HFS_IRQ_MASK_RST 3'h0
`define HFS_COUNT_MAX 3'h7

`endif

// [logic/hfs_pkg.sv]
`default_nettype none
package hfs_pkg;
   // Two-bit lock state as reported by the framer
   typedef enum logic [1:0] {
      lock_lost = 2'h0,
      lock_pending = 2'h1,
      locked = 2'h2,
      lock_degraded = 2'h3
   } hfs_lock_t;
endpackage : hfs_pkg
`default_nettype wire

// [logic/hfs_sat_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module hfs_sat_counter #(
   parameter int WIDTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_clear,
   input wire logic i_inc,
   output logic [WIDTH-1:0] o_count,
   output logic o_saturated
);
   generate
      if (WIDTH < 1 || WIDTH > 31) begin : g_bad
         $error("hfs_sat_counter: WIDTH out of range");
      end
   endgenerate

   localparam logic [WIDTH-1:0] MAX = {WIDTH{1'b1}};
   wire logic at_max;
   wire logic [WIDTH-1:0] next_count;

   assign at_max = (o_count == MAX);
   assign next_count = i_clear ? '0 :
                       (i_inc && !at_max) ? o_count + 1'b1 : o_count;
   assign o_saturated = at_max;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_count <= '0;
      end else begin
         o_count <= next_count;
      end
   end
endmodule : hfs_sat_counter
`default_nettype wire

// [logic/hfs_irq_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module hfs_irq_regs #(
   parameter int NBITS = 3
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [NBITS-1:0] i_set,
   input wire logic i_status_we,
   input wire logic i_mask_we,
   input wire logic [NBITS-1:0] i_wdata,
   output logic [NBITS-1:0] o_status,
   output logic [NBITS-1:0] o_mask,
   output logic o_irq
);
   generate
      if (NBITS < 1 || NBITS > 32) begin : g_bad
         $error("hfs_irq_regs: NBITS out of range");
      end
   endgenerate

   genvar b;
   generate
      for (b = 0; b < NBITS; b++) begin : g_bit
         wire logic clr;
         assign clr = i_status_we && i_wdata[b];
         // Set wins over a write-one clear in the same cycle
         always_ff @(posedge i_mclk) begin
            if (i_rst) begin
               o_status[b] <= 1'b0;
            end else if (i_set[b]) begin
               o_status[b] <= 1'b1;
            end else if (clr) begin
               o_status[b] <= 1'b0;
            end
         end
         always_ff @(posedge i_mclk) begin
            if (i_rst) begin
               o_mask[b] <= 1'b0;
            end else if (i_mask_we) begin
               o_mask[b] <= i_wdata[b];
            end
         end
      end
   endgenerate

   assign o_irq = |(o_status & o_mask);
endmodule : hfs_irq_regs
`default_nettype wire

// [logic/hfs_rx_sync_status.sv]
// Behaviour
// - Entering lock_lost resets receive elastic store
// - No CRC or far-end counting in lock_lost
// - Error event on entering lost, pending, locked
// - Lock_pending enables elastic store and mapper
// - Entering locked reloads store fill target
// - Entering locked resumes error counting
// - Degraded count holds consecutive missing-sync frames
// - Count valid pending/degraded; 000 means one
// - CRC saturated flag when count reaches 255
// - Far-end count 255 sets flag, interrupts
`timescale 1ns/1ps
`default_nettype none
`include "hfs_defs.svh"
module hfs_rx_sync_status
   import hfs_pkg::*;
#(
   parameter int CNT_WIDTH = 8,
   parameter int FILL_WIDTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   // Framer side
   input wire logic [1:0] i_sync_state,
   input wire logic i_frame_strobe,
   input wire logic i_sync_found,
   input wire logic i_crc_mismatch,
   input wire logic i_far_end_block_error,
   // Elastic store and payload mapper control
   output logic o_store_reset,
   output logic o_store_enable,
   output logic o_mapper_enable,
   output logic o_store_fill_load,
   output logic [FILL_WIDTH-1:0] o_store_fill_target,
   output logic o_rx_error_event,
   output logic o_irq,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   generate
      if (CNT_WIDTH != 8) begin : g_bad_cnt
         $error("hfs_rx_sync_status: counters must be 8 bits");
      end
      if (FILL_WIDTH < 1 || FILL_WIDTH > 32) begin : g_bad_fill
         $error("hfs_rx_sync_status: FILL_WIDTH out of range");
      end
      if (`HFS_ST_FAR_END_BLOCK_ERROR_SAT > 7) begin : g_bad_status
         $error("hfs_rx_sync_status: status fields exceed a byte");
      end
   endgenerate

   // Lock state tracking
   hfs_lock_t cur_state;
   hfs_lock_t prev_state;
   wire logic state_change;
   wire logic enter_lost;
   wire logic enter_pending;
   wire logic enter_locked;
   wire logic enter_degraded;
   wire logic in_lost;

   assign cur_state = hfs_lock_t'(i_sync_state);
   assign state_change = (cur_state != prev_state);
   assign enter_lost = state_change && (cur_state == lock_lost);
   assign enter_pending = state_change && (cur_state == lock_pending);
   assign enter_locked = state_change && (cur_state == locked);
   assign enter_degraded = state_change && (cur_state == lock_degraded);
   assign in_lost = (cur_state == lock_lost);

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         prev_state <= lock_lost;
      end else begin
         prev_state <= cur_state;
      end
   end

   // Store reset, fill reload and error event pulses
   wire logic next_store_reset;
   wire logic next_store_fill_load;
   wire logic next_rx_error_event;

   assign next_store_reset = enter_lost;
   assign next_store_fill_load = enter_locked;
   assign next_rx_error_event = enter_lost || enter_pending ||
                                enter_locked;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_store_reset <= 1'b0;
         o_store_fill_load <= 1'b0;
         o_rx_error_event <= 1'b0;
      end else begin
         o_store_reset <= next_store_reset;
         o_store_fill_load <= next_store_fill_load;
         o_rx_error_event <= next_rx_error_event;
      end
   end

   // Store and mapper enables
   wire logic next_enable;
   assign next_enable = enter_lost ? 1'b0 :
                        enter_pending ? 1'b1 : o_store_enable;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_store_enable <= 1'b0;
         o_mapper_enable <= 1'b0;
      end else begin
         o_store_enable <= next_enable;
         o_mapper_enable <= next_enable;
      end
   end

   // Error counting gate
   logic count_on;
   wire logic next_count_on;
   assign next_count_on = enter_lost ? 1'b0 :
                          enter_locked ? 1'b1 : count_on;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         count_on <= 1'b0;
      end else begin
         count_on <= next_count_on;
      end
   end

   wire logic count_ok;
   assign count_ok = count_on && !in_lost;

   // Intermediate frame count
   logic [2:0] frame_count;
   logic frame_seen;
   wire logic count_state;
   wire logic frame_hit;
   wire logic [2:0] next_frame_count;
   wire logic next_frame_seen;

   assign count_state = (cur_state == lock_pending) ||
                        (cur_state == lock_degraded);
   // Pending counts frames with sync; degraded counts frames without
   assign frame_hit = (cur_state == lock_pending) ? i_sync_found :
                      !i_sync_found;
   assign next_frame_seen = (state_change || !count_state) ? 1'b0 :
                            (i_frame_strobe && frame_hit) ? 1'b1 :
                            (i_frame_strobe) ? 1'b0 : frame_seen;
   assign next_frame_count =
      (state_change || !count_state) ? 3'h0 :
      (i_frame_strobe && !frame_hit) ? 3'h0 :
      (i_frame_strobe && frame_seen &&
       frame_count != `HFS_COUNT_MAX) ? frame_count + 3'h1 :
      frame_count;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         frame_count <= 3'h0;
         frame_seen <= 1'b0;
      end else begin
         frame_count <= next_frame_count;
         frame_seen <= next_frame_seen;
      end
   end

   // Per-frame CRC mismatch flag
   logic crc_mismatch;
   wire logic next_crc_mismatch;
   assign next_crc_mismatch = in_lost ? 1'b0 :
                              i_frame_strobe ? i_crc_mismatch :
                              crc_mismatch;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         crc_mismatch <= 1'b0;
      end else begin
         crc_mismatch <= next_crc_mismatch;
      end
   end

   // APB decode
   wire logic setup;
   wire logic access_wr;
   wire logic [9:0] word_idx;
   wire logic aligned;
   wire logic hit_status;
   wire logic hit_crc;
   wire logic hit_far_end_block_error;
   wire logic hit_irq_st;
   wire logic hit_irq_mask;
   wire logic hit_fill;
   wire logic hit_any;

   assign setup = i_psel && !i_penable;
   assign access_wr = i_psel && i_penable && i_pwrite;
   assign word_idx = i_paddr[11:2];
   assign aligned = (i_paddr[1:0] == 2'h0);
   assign hit_status = aligned && (word_idx == {2'h0, `HFS_IDX_STATUS});
   assign hit_crc = aligned && (word_idx == {2'h0, `HFS_IDX_CRC_COUNT});
   assign hit_far_end_block_error = aligned && (word_idx == {2'h0, `HFS_IDX_FAR_END_BLOCK_ERROR_COUNT});
   assign hit_irq_st = aligned &&
                       (word_idx == {2'h0, `HFS_IDX_IRQ_STATUS});
   assign hit_irq_mask = aligned &&
                         (word_idx == {2'h0, `HFS_IDX_IRQ_MASK});
   assign hit_fill = aligned &&
                     (word_idx == {2'h0, `HFS_IDX_FILL_TARGET});
   assign hit_any = hit_status || hit_crc || hit_far_end_block_error || hit_irq_st ||
                    hit_irq_mask || hit_fill;

   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !hit_any;

   // Register write strobes and read capture
   wire logic crc_clear;
   wire logic far_end_block_error_clear;
   wire logic irq_status_we;
   wire logic irq_mask_we;
   wire logic fill_we;
   wire logic rd_capture;

   assign crc_clear = access_wr && hit_crc;
   assign far_end_block_error_clear = access_wr && hit_far_end_block_error;
   assign irq_status_we = access_wr && hit_irq_st;
   assign irq_mask_we = access_wr && hit_irq_mask;
   assign fill_we = access_wr && hit_fill;
   assign rd_capture = setup && !i_pwrite;

   // Error counters; a write of any value clears
   wire logic [7:0] crc_count;
   wire logic [7:0] far_end_block_error_count;
   wire logic crc_sat;
   wire logic far_end_block_error_sat;
   logic crc_sat_d;
   logic far_end_block_error_sat_d;
   wire logic crc_inc;
   wire logic far_end_block_error_inc;

   assign crc_inc = count_ok && i_frame_strobe && i_crc_mismatch;
   assign far_end_block_error_inc = count_ok && i_frame_strobe &&
                     i_far_end_block_error;

   hfs_sat_counter #(
      .WIDTH(CNT_WIDTH)
   ) u_crc_count (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clear(crc_clear),
      .i_inc(crc_inc),
      .o_count(crc_count),
      .o_saturated(crc_sat)
   );

   hfs_sat_counter #(
      .WIDTH(CNT_WIDTH)
   ) u_far_end_block_error_count (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_clear(far_end_block_error_clear),
      .i_inc(far_end_block_error_inc),
      .o_count(far_end_block_error_count),
      .o_saturated(far_end_block_error_sat)
   );

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         crc_sat_d <= 1'b0;
         far_end_block_error_sat_d <= 1'b0;
      end else begin
         crc_sat_d <= crc_sat;
         far_end_block_error_sat_d <= far_end_block_error_sat;
      end
   end

   // Interrupt status and mask
   wire logic [`HFS_IRQ_BITS-1:0] irq_set;
   wire logic [`HFS_IRQ_BITS-1:0] irq_status;
   wire logic [`HFS_IRQ_BITS-1:0] irq_mask;

   assign irq_set[`HFS_IRQ_STATE] = enter_lost || enter_pending ||
                                    enter_locked;
   assign irq_set[`HFS_IRQ_CRC_SAT] = crc_sat && !crc_sat_d;
   assign irq_set[`HFS_IRQ_FAR_END_BLOCK_ERROR_SAT] = far_end_block_error_sat && !far_end_block_error_sat_d;

   hfs_irq_regs #(
      .NBITS(`HFS_IRQ_BITS)
   ) u_irq (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_set(irq_set),
      .i_status_we(irq_status_we),
      .i_mask_we(irq_mask_we),
      .i_wdata(i_pwdata[`HFS_IRQ_BITS-1:0]),
      .o_status(irq_status),
      .o_mask(irq_mask),
      .o_irq(o_irq)
   );

   // Fill target register
   wire logic [FILL_WIDTH-1:0] next_store_fill_target;
   assign next_store_fill_target = fill_we ? i_pwdata[FILL_WIDTH-1:0] :
                                   o_store_fill_target;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_store_fill_target <= FILL_WIDTH'(`HFS_FILL_TARGET_RST);
      end else begin
         o_store_fill_target <= next_store_fill_target;
      end
   end

   // Status word
   wire logic [7:0] status_word;
   assign status_word[`HFS_ST_COUNT_LSB +: 3] = count_state ?
                                               frame_count : 3'h0;
   assign status_word[`HFS_ST_STATE_LSB +: 2] = cur_state;
   assign status_word[`HFS_ST_MISMATCH] = crc_mismatch;
   assign status_word[`HFS_ST_CRC_SAT] = crc_sat;
   assign status_word[`HFS_ST_FAR_END_BLOCK_ERROR_SAT] = far_end_block_error_sat;

   // Read data captured in the setup phase
   wire logic [31:0] rd_mux;
   assign rd_mux =
      hit_status ? {24'h0, status_word} :
      hit_crc ? {24'h0, crc_count} :
      hit_far_end_block_error ? {24'h0, far_end_block_error_count} :
      hit_irq_st ? {{(32-`HFS_IRQ_BITS){1'b0}}, irq_status} :
      hit_irq_mask ? {{(32-`HFS_IRQ_BITS){1'b0}}, irq_mask} :
      hit_fill ? 32'(o_store_fill_target) : 32'h0;

   wire logic [31:0] next_prdata;
   assign next_prdata = rd_capture ? rd_mux : o_prdata;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_prdata <= 32'h0;
      end else begin
         o_prdata <= next_prdata;
      end
   end

   wire logic unused_ok;
   assign unused_ok = enter_degraded;
endmodule : hfs_rx_sync_status
`default_nettype wire

// [dv/hfs_rx_sync_status_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hfs_defs.svh"
module hfs_rx_sync_status_monitor #(
   parameter int FILL_WIDTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [1:0] i_sync_state,
   input wire logic o_store_reset,
   input wire logic o_store_enable,
   input wire logic o_mapper_enable,
   input wire logic o_store_fill_load,
   input wire logic [FILL_WIDTH-1:0] o_store_fill_target,
   input wire logic o_rx_error_event,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_enter(logic [1:0] st);
      i_sync_state == st && $past(i_sync_state) != st;
   endsequence
   sequence s_fill_wr;
      i_psel && i_penable && i_pwrite
         && i_paddr == {2'h0, `HFS_IDX_FILL_TARGET, 2'h0};
   endsequence
   AST_STORE_RESET: assert property (
      s_enter(2'h0) |=> o_store_reset ##1 !o_store_reset)
      else $error("store reset missing on lock loss");
   AST_DISABLE: assert property (
      s_enter(2'h0) |=> !o_store_enable && !o_mapper_enable)
      else $error("store still enabled after lock loss");
   AST_ENABLE: assert property (
      s_enter(2'h1) |=> o_store_enable && o_mapper_enable)
      else $error("store or mapper not enabled");
   AST_EVENT: assert property (
      (s_enter(2'h0) or s_enter(2'h1) or s_enter(2'h2))
      |=> o_rx_error_event)
      else $error("error event missing");
   AST_NO_EVENT: assert property (
      (i_sync_state == $past(i_sync_state) || i_sync_state == 2'h3)
      |=> !o_rx_error_event)
      else $error("spurious error event");
   AST_FILL_LOAD: assert property (
      s_enter(2'h2) |=> o_store_fill_load ##1 !o_store_fill_load)
      else $error("fill target not loaded on lock");
   AST_FILL_WR: assert property (
      s_fill_wr |=> o_store_fill_target == $past(i_pwdata[FILL_WIDTH-1:0]))
      else $error("fill target write lost");
   AST_SLVERR: assert property (
      i_psel && i_penable && i_paddr[1:0] != 2'h0 |-> o_pslverr)
      else $error("unaligned access not refused");
   AST_PREADY: assert property (o_pready)
      else $error("pready low");
endmodule : hfs_rx_sync_status_monitor
bind hfs_rx_sync_status hfs_rx_sync_status_monitor #(
   .FILL_WIDTH(FILL_WIDTH)
) i_hfs_rx_sync_status_monitor (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_sync_state(i_sync_state),
   .o_store_reset(o_store_reset), .o_store_enable(o_store_enable),
   .o_mapper_enable(o_mapper_enable),
   .o_store_fill_load(o_store_fill_load),
   .o_store_fill_target(o_store_fill_target),
   .o_rx_error_event(o_rx_error_event), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr)
);
`default_nettype wire

// [dv/hfs_framer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hfs_framer_model (
   input wire logic i_mclk,
   output logic [1:0] o_sync_state,
   output logic o_frame_strobe,
   output logic o_sync_found,
   output logic o_crc_mismatch,
   output logic o_far_end_block_error
);
   initial begin
      o_sync_state = 2'h0;
      o_frame_strobe = 1'b0;
      o_sync_found = 1'b0;
      o_crc_mismatch = 1'b0;
      o_far_end_block_error = 1'b0;
   end
   task go(input logic [1:0] s);
      @(posedge i_mclk);
      o_sync_state <= s;
   endtask : go
   // Qualifiers flip once the strobe drops
   task frames(input int n, input logic sf, input logic c, input logic f);
      repeat (n) begin
         @(posedge i_mclk);
         o_frame_strobe <= 1'b1;
         o_sync_found <= sf;
         o_crc_mismatch <= c;
         o_far_end_block_error <= f;
         @(posedge i_mclk);
         o_frame_strobe <= 1'b0;
         o_sync_found <= ~sf;
         o_crc_mismatch <= ~c;
         o_far_end_block_error <= ~f;
      end
   endtask : frames
endmodule : hfs_framer_model
`default_nettype wire

// [dv/hfs_rx_sync_status_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hfs_defs.svh"
module hfs_rx_sync_status_test;
   localparam logic [11:0] A_ST = {2'h0, `HFS_IDX_STATUS, 2'h0};
   localparam logic [11:0] A_CRC = {2'h0, `HFS_IDX_CRC_COUNT, 2'h0};
   localparam logic [11:0] A_FE = {2'h0, `HFS_IDX_FAR_END_BLOCK_ERROR_COUNT, 2'h0};
   localparam logic [11:0] A_IS = {2'h0, `HFS_IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] A_MSK = {2'h0, `HFS_IDX_IRQ_MASK, 2'h0};
   localparam logic [11:0] A_FT = {2'h0, `HFS_IDX_FILL_TARGET, 2'h0};
   logic clk, rst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   wire logic [1:0] st;
   wire logic fs, sf, crc, fe;
   logic srst, sen, men, load, ev, irq, pready, pslverr;
   logic [7:0] ft;
   logic [31:0] prdata;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   hfs_framer_model i_hfs_framer_model (.i_mclk(clk), .o_sync_state(st),
      .o_frame_strobe(fs), .o_sync_found(sf), .o_crc_mismatch(crc),
      .o_far_end_block_error(fe));
   hfs_rx_sync_status i_hfs_rx_sync_status (.i_mclk(clk), .i_rst(rst),
      .i_sync_state(st), .i_frame_strobe(fs), .i_sync_found(sf),
      .i_crc_mismatch(crc), .i_far_end_block_error(fe),
      .o_store_reset(srst), .o_store_enable(sen), .o_mapper_enable(men),
      .o_store_fill_load(load), .o_store_fill_target(ft),
      .o_rx_error_event(ev), .o_irq(irq), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr));
   always #2.5 clk = ~clk;
   task summarize;
      if (err_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_count++;
         summarize();
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rd
   task t_regs;
      logic [31:0] r;
      logic e;
      rd(A_ST, 32'h0);
      rd(A_MSK, 32'h0);
      rd(A_FT, 32'h0);
      wr(A_FT, 32'h5a);
      rd(A_FT, 32'h5a);
      apb(1'b0, 12'h3fc, 32'h0, r, e);
      chk(r, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, A_FT + 12'h1, 32'h0, r, e);
      chk(e, 1'b1);
      rd(A_FT, 32'h5a);
   endtask : t_regs
   task t_states;
      logic [1:0] seq [4];
      logic [3:0] xev;
      logic [31:0] r;
      logic e;
      seq = '{2'h1, 2'h2, 2'h3, 2'h0};
      xev = 4'b1101;
      for (int i = 0; i < 4; i++) begin
         i_hfs_framer_model.go(seq[i]);
         @(posedge clk);
         #1;
         chk(ev, xev[3-i]);
         chk({sen, men}, {2{i != 3}});
         chk({load, ft}, {i == 1, 8'h5a});
         chk(srst, i == 3);
         apb(1'b0, A_ST, 32'h0, r, e);
         chk(r[4:3], seq[i]);
      end
      rd(A_IS, 32'h1);
      chk(irq, 1'b0);
      wr(A_IS, 32'h7);
      rd(A_IS, 32'h0);
   endtask : t_states
   task t_count;
      i_hfs_framer_model.go(2'h1);
      i_hfs_framer_model.frames(3, 1'b1, 1'b0, 1'b0);
      rd(A_ST, 32'h0a);
      i_hfs_framer_model.go(2'h3);
      i_hfs_framer_model.frames(2, 1'b0, 1'b0, 1'b0);
      rd(A_ST, 32'h19);
      i_hfs_framer_model.frames(7, 1'b0, 1'b0, 1'b0);
      rd(A_ST, 32'h1f);
      i_hfs_framer_model.go(2'h2);
      rd(A_ST, 32'h10);
   endtask : t_count
   task t_crc;
      i_hfs_framer_model.go(2'h0);
      i_hfs_framer_model.frames(3, 1'b1, 1'b1, 1'b1);
      rd(A_ST, 32'h0);
      rd(A_CRC, 32'h0);
      rd(A_FE, 32'h0);
      i_hfs_framer_model.go(2'h2);
      i_hfs_framer_model.frames(254, 1'b1, 1'b1, 1'b0);
      rd(A_CRC, 32'hfe);
      rd(A_ST, 32'h30);
      i_hfs_framer_model.frames(2, 1'b1, 1'b1, 1'b0);
      rd(A_CRC, 32'hff);
      rd(A_ST, 32'h70);
      i_hfs_framer_model.frames(1, 1'b1, 1'b0, 1'b0);
      rd(A_ST, 32'h50);
      wr(A_CRC, 32'h0);
      rd(A_ST, 32'h10);
   endtask : t_crc
   task t_far_end_block_error;
      wr(A_IS, 32'h7);
      wr(A_MSK, 32'h4);
      i_hfs_framer_model.frames(254, 1'b1, 1'b0, 1'b1);
      rd(A_FE, 32'hfe);
      rd(A_ST, 32'h10);
      chk(irq, 1'b0);
      i_hfs_framer_model.frames(1, 1'b1, 1'b0, 1'b1);
      rd(A_FE, 32'hff);
      rd(A_ST, 32'h90);
      rd(A_IS, 32'h4);
      chk(irq, 1'b1);
      wr(A_IS, 32'h4);
      #1;
      chk(irq, 1'b0);
   endtask : t_far_end_block_error
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_states();
      t_count();
      t_crc();
      t_far_end_block_error();
      summarize();
   end
endmodule : hfs_rx_sync_status_test
`default_nettype wire
